// ==== core/adsc_pkg.sv ====
package adsc_pkg;

////////////////////////////////////////////////////////////////////////////////
localparam logic [4:0] IDX_CTL1 = 5'h00, IDX_CTL2 = 5'h01, IDX_CTL3 = 5'h02;
localparam logic [4:0] IDX_CHS = 5'h03;
localparam int B_BUF = 4;
localparam logic [15:0] CTL_RESET = 16'h0000;
localparam int B_EN = 15, B_ISTOP = 13, B_RES = 10, B_RESULT_FORMAT = 8, B_SRC = 5;
localparam int B_SIM = 3, B_AUTO_SAMPLE = 2, B_SAMPLE_BIT = 1, B_DONE = 0;
localparam int B_REFERENCE_SELECT = 13, B_SCAN = 10, B_CHANNEL_COUNT = 8, B_INTERRUPT_PACING = 2, B_SPLIT_BUFFER = 1;
localparam int B_ALTERNATE_INPUT = 0, B_CONV_CLOCK_SOURCE = 15, B_AUTO_SAMPLE_TIME = 8, B_CONV_CLOCK_DIVIDER = 0;
localparam int B_NB = 9, B_SB = 8, B_NA = 1, B_SA = 0;
localparam logic [2:0] SRC_SW = 3'h0, SRC_EXT = 3'h1, SRC_TMR3 = 3'h2;
localparam logic [2:0] SRC_PWM1 = 3'h3, SRC_PWM2 = 3'h5, SRC_AUTO = 3'h7;

typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_CONV   = 3'h4
} adsc_state_type;

typedef struct packed {
    logic pwm1;
    logic pwm2;
    logic timer3;
    logic external_interrupt_pin;
} adsc_trig_type;

typedef struct packed {
    logic       sampling;
    logic       sample_all;
    logic       conv_start;
    logic [1:0] channel;
    logic       use_b;
    logic       scan_step;
    logic       ref_pos_ext;
    logic       ref_neg_ext;
    logic       neg_b_vref;
    logic       ch123_pos_sel;
} adsc_core_type;
endpackage

// ==== core/adsc_top.sv ====
`timescale 1ns/10ps
module adsc_top import adsc_pkg::*; #(
    parameter int BUF_DEPTH = 16
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [4:0]    addr,
    input  wire logic [15:0]   wdata,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    output logic [15:0]        rd_data,
    input  wire logic          idle_mode,
    input  wire logic          rc_tick,
    input  wire adsc_trig_type trig,
    input  wire logic          conv_done,
    input  wire logic [11:0]   conv_data,
    output adsc_core_type      core,
    output logic               irq
);
localparam int AW = $clog2(BUF_DEPTH);

logic rst_s1_r, rst_sync_n;
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rst_s1_r   <= 1'b0;
        rst_sync_n <= 1'b0;
    end else begin
        rst_s1_r   <= 1'b1;
        rst_sync_n <= rst_s1_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
logic       module_enable_r, idle_stop_r, resolution_mode_r, simultaneous_sample_r;
logic       auto_sample_r, complete_r, scan_enable_r, buffer_half_status_r;
logic       split_buffer_r, alternate_input_r, conv_clock_source_r;
logic       ch_one_three_pos_b_r, pos_a_r;
logic [1:0] result_format_r, channel_count_r, ch_one_three_neg_b_r, neg_a_r;
logic [2:0] trigger_source_r, reference_select_r;
logic [3:0] interrupt_pacing_r, seq_cnt_r;
logic [4:0] auto_sample_time_r, auto_sample_time_cnt_r;
logic [5:0] conv_clock_divider_r, tad_cnt_r;
logic [1:0] ch_r, last_ch;
logic [AW-1:0] widx_r;
logic [15:0]   buf_r [BUF_DEPTH];
logic [15:0]   fmt_word;
logic          use_b_r, ext_prev_r, irq_nxt;
adsc_state_type state_r;
adsc_core_type  core_nxt;

wire wr_c1 = wr_en && addr == IDX_CTL1;
wire wr_c2 = wr_en && addr == IDX_CTL2;
wire wr_c3 = wr_en && addr == IDX_CTL3;
wire wr_ch = wr_en && addr == IDX_CHS;
wire run = module_enable_r && !(idle_stop_r && idle_mode);
wire sim_eff = simultaneous_sample_r && !resolution_mode_r;
wire [1:0] channel_count_eff = resolution_mode_r ? 2'h0 : channel_count_r;

// channel_count_eff is already zero in 12-bit mode, and code 11 must not hit two items
always_comb begin
    if (channel_count_eff[1]) begin
        last_ch = 2'h3;
    end else if (channel_count_eff[0]) begin
        last_ch = 2'h1;
    end else begin
        last_ch = 2'h0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// software-visible configuration
always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        {module_enable_r, idle_stop_r, resolution_mode_r} <= 3'h0;
        {result_format_r, trigger_source_r}              <= 5'h00;
        {simultaneous_sample_r, auto_sample_r}           <= 2'h0;
        {reference_select_r, scan_enable_r, channel_count_r} <= 6'h00;
        {interrupt_pacing_r, split_buffer_r, alternate_input_r} <= 6'h00;
        {conv_clock_source_r, auto_sample_time_r, conv_clock_divider_r} <= 12'h000;
        {ch_one_three_neg_b_r, ch_one_three_pos_b_r, neg_a_r, pos_a_r} <= 6'h00;
    end else begin
        if (wr_c1) begin
            module_enable_r       <= wdata[B_EN];
            idle_stop_r           <= wdata[B_ISTOP];
            // mode change only honoured while the converter is off
            if (!module_enable_r) begin
                resolution_mode_r <= wdata[B_RES];
            end
            result_format_r       <= wdata[B_RESULT_FORMAT+:2];
            trigger_source_r      <= wdata[B_SRC+:3];
            simultaneous_sample_r <= wdata[B_SIM];
            auto_sample_r         <= wdata[B_AUTO_SAMPLE];
        end
        if (wr_c2) begin
            reference_select_r <= wdata[B_REFERENCE_SELECT+:3];
            scan_enable_r      <= wdata[B_SCAN];
            channel_count_r    <= wdata[B_CHANNEL_COUNT+:2];
            interrupt_pacing_r <= wdata[B_INTERRUPT_PACING+:4];
            split_buffer_r     <= wdata[B_SPLIT_BUFFER];
            alternate_input_r  <= wdata[B_ALTERNATE_INPUT];
        end
        if (wr_c3) begin
            conv_clock_source_r  <= wdata[B_CONV_CLOCK_SOURCE];
            auto_sample_time_r   <= wdata[B_AUTO_SAMPLE_TIME+:5];
            conv_clock_divider_r <= wdata[B_CONV_CLOCK_DIVIDER+:6];
        end
        if (wr_ch) begin
            ch_one_three_neg_b_r <= wdata[B_NB+:2];
            ch_one_three_pos_b_r <= wdata[B_SB];
            neg_a_r              <= wdata[B_NA+:2];
            pos_a_r              <= wdata[B_SA];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// conversion clock: divider runs free so a period is always whole
wire tad_tick = conv_clock_source_r ? rc_tick : (tad_cnt_r >= conv_clock_divider_r);

always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        tad_cnt_r <= 6'h00;
    end else if (tad_cnt_r >= conv_clock_divider_r) begin
        tad_cnt_r <= 6'h00;
    end else begin
        tad_cnt_r <= tad_cnt_r + 6'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
logic trig_hit;
wire  sw_start = wr_c1 && wdata[B_SAMPLE_BIT] && !auto_sample_r && state_r == ST_IDLE;
wire  sw_end   = wr_c1 && !wdata[B_SAMPLE_BIT] && state_r == ST_SAMPLE;
wire  seq_last = state_r == ST_CONV && conv_done && ch_r == last_ch;
wire  end_sample_bit = state_r == ST_SAMPLE
               && (trigger_source_r == SRC_SW ? sw_end : trig_hit);
wire  enter_sample_bit = (state_r == ST_IDLE && (sw_start || auto_sample_r))
                 || (seq_last && auto_sample_r);
wire  seq_end  = seq_last && seq_cnt_r == interrupt_pacing_r;

always_comb begin
    unique case (trigger_source_r)
        SRC_EXT:  trig_hit = trig.external_interrupt_pin && !ext_prev_r;
        SRC_TMR3: trig_hit = trig.timer3;
        SRC_PWM1: trig_hit = trig.pwm1;
        SRC_PWM2: trig_hit = trig.pwm2;
        SRC_AUTO: trig_hit = auto_sample_time_cnt_r >= auto_sample_time_r;
        default:  trig_hit = 1'b0; // reserved codes never end sampling
    endcase
end

always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        ext_prev_r <= 1'b0;
        auto_sample_time_cnt_r <= 5'h00;
    end else begin
        ext_prev_r <= trig.external_interrupt_pin;
        if (state_r != ST_SAMPLE) begin
            auto_sample_time_cnt_r <= 5'h00;
        end else if (tad_tick && auto_sample_time_cnt_r != 5'h1F) begin
            auto_sample_time_cnt_r <= auto_sample_time_cnt_r + 5'h01;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        state_r <= ST_IDLE;
        ch_r    <= 2'h0;
    end else if (!run) begin
        state_r <= ST_IDLE;
        ch_r    <= 2'h0;
    end else begin
        unique case (state_r)
            ST_IDLE: begin
                if (enter_sample_bit) begin
                    state_r <= ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (end_sample_bit) begin
                    state_r <= ST_CONV;
                    ch_r    <= 2'h0;
                end
            end
            ST_CONV: begin
                if (seq_last) begin
                    state_r <= auto_sample_r ? ST_SAMPLE : ST_IDLE;
                end else if (conv_done) begin
                    ch_r <= ch_r + 2'h1;
                end
            end
        endcase
    end
end

// set wins over both clears
always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        complete_r <= 1'b0;
    end else if (seq_last && run) begin
        complete_r <= 1'b1;
    end else if ((wr_c1 && !wdata[B_DONE]) || core_nxt.conv_start) begin
        complete_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
always_comb begin
    unique case ({resolution_mode_r, result_format_r})
        3'b011:  fmt_word = {~conv_data[9], conv_data[8:0], 6'h00};
        3'b010:  fmt_word = {conv_data[9:0], 6'h00};
        3'b001:  fmt_word = {{7{~conv_data[9]}}, conv_data[8:0]};
        3'b000:  fmt_word = {6'h00, conv_data[9:0]};
        3'b111:  fmt_word = {~conv_data[11], conv_data[10:0], 4'h0};
        3'b110:  fmt_word = {conv_data[11:0], 4'h0};
        3'b101:  fmt_word = {{5{~conv_data[11]}}, conv_data[10:0]};
        default: fmt_word = {4'h0, conv_data[11:0]};
    endcase
end

// buffer words are plain flops; software reads them over the register port
always_ff @(posedge clk) begin
    if (run && state_r == ST_CONV && conv_done) begin
        buf_r[widx_r] <= fmt_word;
    end
end

always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        widx_r               <= '0;
        seq_cnt_r            <= 4'h0;
        buffer_half_status_r <= 1'b0;
    end else if (run && state_r == ST_CONV && conv_done) begin
        if (seq_end) begin
            seq_cnt_r <= 4'h0;
            if (split_buffer_r) begin
                buffer_half_status_r <= !buffer_half_status_r;
                widx_r <= buffer_half_status_r ? '0 : AW'(BUF_DEPTH / 2);
            end else begin
                buffer_half_status_r <= 1'b0;
                widx_r               <= '0;
            end
        end else begin
            widx_r <= widx_r + AW'(1);
            if (seq_last) begin
                seq_cnt_r <= seq_cnt_r + 4'h1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        use_b_r <= 1'b0;
    end else if (!alternate_input_r) begin
        use_b_r <= 1'b0;
    end else if (end_sample_bit && run) begin
        use_b_r <= !use_b_r;
    end
end

always_comb begin
    core_nxt               = '0;
    core_nxt.sampling      = run && (state_r == ST_SAMPLE ? !end_sample_bit : enter_sample_bit);
    core_nxt.sample_all    = sim_eff;
    core_nxt.conv_start    = run && (end_sample_bit || (state_r == ST_CONV && conv_done && !seq_last));
    core_nxt.channel       = end_sample_bit ? 2'h0 : ch_r + 2'h1;
    core_nxt.use_b         = use_b_r;
    core_nxt.scan_step     = run && enter_sample_bit && scan_enable_r && !use_b_r;
    core_nxt.ref_pos_ext   = !reference_select_r[2] && reference_select_r[0];
    core_nxt.ref_neg_ext   = !reference_select_r[2] && reference_select_r[1];
    core_nxt.neg_b_vref    = !resolution_mode_r && !ch_one_three_neg_b_r[1];
    core_nxt.ch123_pos_sel = use_b_r ? ch_one_three_pos_b_r : pos_a_r;
    irq_nxt                = run && seq_end;
end

always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        core <= '0;
        irq  <= 1'b0;
    end else begin
        core <= core_nxt;
        irq  <= irq_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data stand one cycle only; unmapped addresses read zero
always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        rd_data <= CTL_RESET;
    end else if (!rd_en) begin
        rd_data <= 16'h0000;
    end else if (addr[B_BUF]) begin
        rd_data <= (32'(addr[3:0]) < BUF_DEPTH) ? buf_r[addr[AW-1:0]] : 16'h0000;
    end else begin
        unique case (addr)
            IDX_CTL1: rd_data <= {module_enable_r, 1'b0, idle_stop_r, 2'h0, resolution_mode_r,
                                  result_format_r, trigger_source_r, 1'b0, sim_eff,
                                  auto_sample_r, state_r == ST_SAMPLE, complete_r};
            IDX_CTL2: rd_data <= {reference_select_r, 2'h0, scan_enable_r, channel_count_eff,
                                  buffer_half_status_r, 1'b0, interrupt_pacing_r,
                                  split_buffer_r, alternate_input_r};
            IDX_CTL3: rd_data <= {conv_clock_source_r, 2'h0, auto_sample_time_r, 2'h0,
                                  conv_clock_divider_r};
            IDX_CHS:  rd_data <= {5'h00, ch_one_three_neg_b_r, ch_one_three_pos_b_r, 5'h00,
                                  neg_a_r, pos_a_r};
            default:  rd_data <= 16'h0000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge clk); endclocking
default disable iff (!rst_sync_n);

sequence seq_end_s;
    run && state_r == ST_CONV && conv_done && ch_r == last_ch
        && seq_cnt_r == interrupt_pacing_r;
endsequence

a_off_stays_idle: assert property (!module_enable_r |=> state_r == ST_IDLE)
    else $error("converter active while disabled");
a_idle_stop_halt: assert property (idle_stop_r && idle_mode |=> state_r == ST_IDLE)
    else $error("converter active in idle with stop set");
a_single_ch_12b: assert property (resolution_mode_r && state_r == ST_CONV |-> ch_r == 2'h0)
    else $error("extra channel in 12-bit mode");
a_fmt_int10: assert property (run && state_r == ST_CONV && conv_done && !resolution_mode_r
    && result_format_r == 2'h0 |=> buf_r[$past(widx_r)] == {6'h00, $past(conv_data[9:0])})
    else $error("10-bit integer format wrong");
a_trig_ends_sample_bit: assert property (run && state_r == ST_SAMPLE && trigger_source_r != SRC_SW
    && trig_hit |=> state_r == ST_CONV ##0 core.conv_start)
    else $error("trigger did not start conversion");
a_done_clr_start: assert property (run && end_sample_bit |=> !complete_r)
    else $error("complete bit not cleared at start");
a_irq_pacing: assert property (seq_end_s |=> irq && seq_cnt_r == 4'h0)
    else $error("interrupt pacing wrong");
a_split_toggle: assert property (seq_end_s ##0 split_buffer_r
    |=> buffer_half_status_r != $past(buffer_half_status_r))
    else $error("buffer half did not alternate");
a_auto_restart: assert property (seq_end_s ##0 auto_sample_r |=> state_r == ST_SAMPLE)
    else $error("auto sample did not restart");
a_auto_count: assert property (run && state_r == ST_SAMPLE && trigger_source_r == SRC_AUTO
    && auto_sample_time_cnt_r >= auto_sample_time_r |=> state_r == ST_CONV)
    else $error("auto sample time not honoured");

endmodule // adsc_top

// ==== sim/adsc_core_model.sv ====
`timescale 1ns/10ps
module adsc_core_model import adsc_pkg::*; (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire adsc_core_type core,
    input  wire logic [3:0]    lat,
    output logic               conv_done,
    output logic [11:0]        conv_data
);
    logic [3:0]  wait_r;
    logic        busy_r;
    logic [11:0] val_r;
    ////////////////////////////////////////////////////////////////////////////
    // data toggles outside conv_done so a stale capture never looks right
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r    <= 1'b0;
            wait_r    <= 4'h0;
            val_r     <= 12'h5A3;
            conv_done <= 1'b0;
            conv_data <= 12'hA5C;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (core.conv_start) begin
                busy_r <= 1'b1;
                wait_r <= lat;
            end else if (busy_r && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (busy_r) begin
                busy_r    <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= val_r;
                val_r     <= val_r + 12'h29B;
            end
        end
    end
endmodule // adsc_core_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top import adsc_pkg::*;;
    logic          clk, rst_n, wr_en, rd_en, idle_mode, rc_tick, conv_done, irq;
    logic [4:0]    addr;
    logic [15:0]   wdata, rd_data, v, c;
    logic [11:0]   conv_data;
    logic [3:0]    lat;
    logic [2:0]    rc_cnt;
    adsc_trig_type trig;
    adsc_core_type core;
    int            failures, checks, irq_cnt, starts, n, scans;
    logic [11:0]   data_q[$];
    logic [1:0]    ch_q[$];
    logic [1:0]    ub_q[$];
    logic [2:0]    srcs[4] = '{3'h1, 3'h2, 3'h3, 3'h5};
    logic [3:0]    hits[4] = '{4'h1, 4'h2, 4'h8, 4'h4};
    adsc_top i_adsc_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .idle_mode(idle_mode), .rc_tick(rc_tick),
        .trig(trig), .conv_done(conv_done), .conv_data(conv_data), .core(core), .irq(irq));
    adsc_core_model i_adsc_core_model (.clk(clk), .rst_n(rst_n), .core(core), .lat(lat),
        .conv_done(conv_done), .conv_data(conv_data));
    ////////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    always @(posedge clk) begin
        rc_cnt  <= rc_cnt + 3'h1;
        rc_tick <= (rc_cnt == 3'h7);
        if (core.conv_start) begin
            ch_q.push_back(core.channel);
            ub_q.push_back({core.use_b, core.ch123_pos_sel});
            starts++;
        end
        if (conv_done) begin
            data_q.push_back(conv_data);
        end
        if (irq) begin
            irq_cnt++;
        end
        if (core.scan_step) begin
            scans++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // read data stand one cycle only; taken at the edge that closes that cycle
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        d = rd_data;
    endtask
    task automatic wait_done(output logic [15:0] d);
        int k;
        k = 0;
        d = 16'h0000;
        while (d[B_DONE] !== 1'b1 && k < 60) begin
            rd(IDX_CTL1, d);
            k++;
        end
        chk("done_bit", d[B_DONE], 1'b1);
    endtask
    task automatic sw_conv(input logic [15:0] cfg, input logic sa);
        logic [15:0] d;
        // enable first: a start bit written beside the enable is dropped
        wr(IDX_CTL1, cfg);
        wr(IDX_CTL1, cfg | 16'h0002);
        repeat (3) @(posedge clk);
        #1;
        chk("sampling", core.sampling, 1'b1);
        chk("sample_all", core.sample_all, sa);
        wr(IDX_CTL1, cfg);
        wait_done(d);
    endtask
    function automatic logic [15:0] fmt(input logic r, input logic [1:0] f, input logic [11:0] d);
        case ({r, f})
            3'h3: return {~d[9], d[8:0], 6'h00};
            3'h2: return {d[9:0], 6'h00};
            3'h1: return {{7{~d[9]}}, d[8:0]};
            3'h0: return {6'h00, d[9:0]};
            3'h7: return {~d[11], d[10:0], 4'h0};
            3'h6: return {d, 4'h0};
            3'h5: return {{5{~d[11]}}, d[10:0]};
            default: return {4'h0, d};
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        end_of_test();
    end
    initial begin
        {clk, rst_n, wr_en, rd_en, idle_mode, rc_tick, rc_cnt, trig} = '0;
        {addr, wdata, failures, checks, irq_cnt, starts, scans} = '0;
        lat = 4'h2;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 5; a++) begin
            rd(5'(a), v);
            chk("reset_value", v, CTL_RESET);
        end
        wr(IDX_CTL3, 16'hFFFF);
        rd(IDX_CTL3, v);
        chk("ctl3", v, 16'h9F3F);
        wr(IDX_CHS, 16'hFFFF);
        rd(IDX_CHS, v);
        chk("chs", v, 16'h0707);
        wr(5'h04, 16'hFFFF);
        rd(5'h04, v);
        chk("unmapped", v, 16'h0000);
        wr(IDX_CHS, 16'h0000);
        wr(IDX_CTL3, 16'h0000);
        for (int r = 0; r < 2; r++) begin
            for (int f = 0; f < 4; f++) begin
                c = (16'(r) << B_RES) | (16'(f) << B_RESULT_FORMAT);
                wr(IDX_CTL1, c);
                sw_conv(c | 16'h8000, 1'b0);
                rd(5'h10, v);
                chk("result", v, fmt(r[0], f[1:0], data_q[$]));
            end
        end
        chk("irq_count", 16'(irq_cnt), 16'h0008);
        // enabled: resolution stays, sim bit reads zero in 12-bit mode, done cleared by zero
        wr(IDX_CTL1, 16'h8008);
        rd(IDX_CTL1, v);
        chk("ctl1_12bit", v, 16'h8400);
        wr(IDX_CTL2, 16'h0300);
        rd(IDX_CTL2, v);
        chk("channel_count_12bit", v, 16'h0000);
        wr(IDX_CTL1, 16'h0000);
        wr(IDX_CTL1, 16'h0001);
        rd(IDX_CTL1, v);
        chk("done_write_one", v, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            wr(IDX_CTL2, 16'(k) << B_REFERENCE_SELECT);
            repeat (2) @(posedge clk);
            #1;
            chk("ref_pos", core.ref_pos_ext, (k == 1 || k == 3));
            chk("ref_neg", core.ref_neg_ext, (k == 2 || k == 3));
        end
        for (int k = 0; k < 4; k++) begin
            wr(IDX_CHS, 16'(k) << B_NB);
            repeat (2) @(posedge clk);
            #1;
            chk("neg_b_vref", core.neg_b_vref, 16'(k < 2));
        end
        wr(IDX_CTL2, 16'h0600);
        sw_conv(16'h8000, 1'b0);
        chk("scan_step", 16'(scans), 16'h0001);
        for (int k = 0; k < 4; k++) begin
            chk("channel", 16'(ch_q[ch_q.size() - 4 + k]), 16'(k));
            rd(5'(16 + k), v);
            chk("buffer", v, fmt(1'b0, 2'h0, data_q[data_q.size() - 4 + k]));
        end
        wr(IDX_CTL2, 16'h0100);
        sw_conv(16'h8008, 1'b1);
        chk("sim_channel", 16'(ch_q[$]), 16'h0001);
        for (int k = 0; k < 4; k++) begin
            c = 16'h8000 | (16'(srcs[k]) << B_SRC);
            wr(IDX_CTL2, 16'h0000);
            wr(IDX_CTL1, c | 16'h0002);
            repeat (3) @(posedge clk);
            trig <= ~hits[k];
            @(posedge clk);
            trig <= 4'h0;
            repeat (3) @(posedge clk);
            #1;
            chk("other_trigger", core.sampling, 1'b1);
            trig <= hits[k];
            @(posedge clk);
            trig <= 4'h0;
            wait_done(v);
            chk("sample_cleared", v[B_SAMPLE_BIT], 1'b0);
        end
        // auto counter: 4 x 3 cycles from the divided clock, then 2 x 8 from the rc tick
        for (int k = 0; k < 2; k++) begin
            wr(IDX_CTL3, (k == 0) ? 16'h0402 : 16'h8200);
            wr(IDX_CTL1, 16'h80E2);
            n = 0;
            while (core.conv_start !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("auto_time", (k == 0) ? (n >= 12 && n <= 18) : (n >= 8 && n <= 28), 1'b1);
            wait_done(v);
        end
        idle_mode <= 1'b1;
        n = starts;
        wr(IDX_CTL1, 16'h80E4);
        repeat (200) @(posedge clk);
        chk("auto_restart", 16'(starts - n >= 3), 16'h0001);
        wr(IDX_CTL1, 16'hA0E4);
        repeat (30) @(posedge clk);
        n = starts;
        repeat (100) @(posedge clk);
        chk("idle_stop", 16'(starts - n), 16'h0000);
        idle_mode <= 1'b0;
        wr(IDX_CTL1, 16'h00E4);
        repeat (30) @(posedge clk);
        n = starts;
        repeat (100) @(posedge clk);
        #1;
        chk("module_off", 16'(starts - n) | 16'(core.sampling), 16'h0000);
        wr(IDX_CTL1, 16'h0000);
        wr(IDX_CTL2, 16'h0007);
        wr(IDX_CHS, 16'h0100);
        lat <= 4'hA;
        n = irq_cnt;
        for (int k = 0; k < 4; k++) begin
            sw_conv(16'h8000, 1'b0);
            rd(IDX_CTL2, v);
            chk("irq_pacing", 16'(irq_cnt - n), 16'((k + 1) / 2));
            chk("buffer_half", v[7], (k == 1 || k == 2));
        end
        for (int k = 0; k < 4; k++) begin
            rd(5'((k < 2) ? 16 + k : 22 + k), v);
            chk("split_fill", v, {6'h00, data_q[data_q.size() - 4 + k][9:0]});
            chk("alternate", 16'(ub_q[ub_q.size() - 4 + k]), k[0] ? 16'h0003 : 16'h0000);
        end
        end_of_test();
    end
endmodule // tb_top
